/* rtl/smfw_core.sv */
// serial port: clock modes, error flags, interrupt and halt wake-up
// assumes: cpu access strobes are one-cycle pulses on CLK_SYS;
// link pins are asynchronous and are synchronised here
`timescale 1ns/1ps

// How it works
// - polarity and phase pick the capture edge
// - idle clock level equals selected polarity
// - master with select low sets fault flag
// - fault clears port enable and controller role
// - fault clears after status read, control write
// - during fault, enable and role writes refused
// - byte done with done flag set: overrun
// - overrun keeps first byte, later bytes dropped
// - status read clears the overrun flag
// - data write during transfer dropped, collision flagged
// - collision flag never raises an interrupt
// - received byte copied to separate read buffer
// - wait mode keeps port running, events wake
// - halt freezes cpu access and master clock; armed slave keeps receiving
// - extra bytes before clear in halt: overrun
// - only transfer done wakes slave from halt
// - halt wake needs select low at entry
// - one interrupt: flag, enable and mask clear
// - unwritten slave returns previous byte to master
// - done flag set per byte, cleared by sequence
// - done flag blocks data writes until status read
// - soft management takes select from level bit
module smfw_core (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CR_WR,
  input wire logic IRQ_ENABLE_BIT_IN,
  input wire logic PORT_ENABLE_BIT_IN,
  input wire logic CONTROLLER_ROLE_BIT_IN,
  input wire logic CLOCK_POLARITY_SEL_IN,
  input wire logic CLOCK_PHASE_SEL_IN,
  input wire logic [2:0] RATE_SEL_IN,
  input wire logic CSR_RD,
  input wire logic SELECT_SOFT_MGMT,
  input wire logic SELECT_SOFT_LEVEL,
  input wire logic OUTPUT_DISABLE,
  input wire logic DR_WR,
  input wire logic [7:0] DR_WDATA,
  input wire logic DR_RD,
  output logic [7:0] DR_RDATA,
  input wire logic COND_CODE_MASK,
  input wire logic HALT,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic SEL_N_I,
  output logic TRANSFER_DONE_FLAG,
  output logic WRITE_COLLISION_FLAG,
  output logic OVERRUN_FLAG,
  output logic MODE_FAULT_FLAG,
  output logic PORT_ENABLE_BIT,
  output logic CONTROLLER_ROLE_BIT,
  output logic IRQ,
  output logic WAKE_HALT
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic sck_s1_r, sck_s2_r, sck_s3_r;
  logic mosi_s1_r, mosi_s2_r, miso_s1_r, miso_s2_r, sel_s1_r, sel_s2_r;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      {sck_s1_r, sck_s2_r, sck_s3_r} <= 3'h0;
      {mosi_s1_r, mosi_s2_r, miso_s1_r, miso_s2_r} <= 4'h0;
      {sel_s1_r, sel_s2_r} <= 2'h3;
    end else begin
      sck_s1_r <= SCK_I;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      mosi_s1_r <= MOSI_I;
      mosi_s2_r <= mosi_s1_r;
      miso_s1_r <= MISO_I;
      miso_s2_r <= miso_s1_r;
      sel_s1_r <= SEL_N_I;
      sel_s2_r <= sel_s1_r;
    end
  end

  function automatic logic [5:0] half_reload(input logic [2:0] rate);
    logic [5:0] r;
    r = smfw_pkg::HALF_DIV64;
    case (rate)
      smfw_pkg::RATE_DIV4: r = smfw_pkg::HALF_DIV4;
      smfw_pkg::RATE_DIV8: r = smfw_pkg::HALF_DIV8;
      smfw_pkg::RATE_DIV16: r = smfw_pkg::HALF_DIV16;
      smfw_pkg::RATE_DIV32: r = smfw_pkg::HALF_DIV32;
      smfw_pkg::RATE_DIV128: r = smfw_pkg::HALF_DIV128;
      default: r = smfw_pkg::HALF_DIV64;
    endcase
    return r;
  endfunction : half_reload

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic irq_en_r, pe_r, role_r, pol_r, pha_r;
  logic irq_en_nxt, pe_nxt, role_nxt, pol_nxt, pha_nxt;
  logic [2:0] rate_r, rate_nxt;
  logic tdf_r, write_collision_flag_r, ovr_r, mode_fault_flag_r, tdf_seen_r, write_collision_flag_seen_r, mode_fault_flag_seen_r;
  logic tdf_nxt, write_collision_flag_nxt, ovr_nxt, mode_fault_flag_nxt, tdf_seen_nxt, write_collision_flag_seen_nxt;
  logic mode_fault_flag_seen_nxt;
  logic [7:0] sh_r, sh_nxt, rxb_r, rxb_nxt, byte_in;
  logic in_r, in_nxt, sck_r, sck_nxt, halt_d_r, arm_r, arm_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [5:0] div_r, div_nxt;
  smfw_pkg::smfw_mst_t mst_r, mst_nxt;

  logic sel_int, fault, slave_on, lead, trail, samp, shft, din;
  logic tick, busy, done, dr_ok;

  // ---------------------------------------------------------------
  // edge detection and transfer engine
  // ---------------------------------------------------------------
  // soft management replaces the select pin
  assign sel_int = SELECT_SOFT_MGMT ? SELECT_SOFT_LEVEL : sel_s2_r;
  assign fault = role_r & pe_r & ~sel_int & ~HALT;
  // in halt the slave only runs when armed at entry
  assign slave_on = pe_r & ~role_r & ~sel_int & (~HALT | arm_r);
  assign tick = (mst_r == smfw_pkg::ST_RUN) & (div_r == 6'h00) & ~HALT;
  assign lead = role_r ? tick & (sck_r == pol_r)
              : slave_on & (pol_r ? (~sck_s2_r & sck_s3_r) : (sck_s2_r & ~sck_s3_r));
  assign trail = role_r ? tick & (sck_r != pol_r)
               : slave_on & (pol_r ? (sck_s2_r & ~sck_s3_r) : (~sck_s2_r & sck_s3_r));
  assign samp = pha_r ? trail : lead;
  assign shft = pha_r ? lead : trail;
  assign din = role_r ? miso_s2_r : mosi_s2_r;
  assign busy = role_r ? (mst_r == smfw_pkg::ST_RUN)
              : (pe_r & ~sel_int & (~pha_r | (cnt_r != smfw_pkg::CNT_RST)));
  // writes stay blocked while done flag is up and status unread
  assign dr_ok = DR_WR & ~HALT & ~(tdf_r & ~tdf_seen_r);

  always_comb begin
    irq_en_nxt = irq_en_r;
    pe_nxt = pe_r;
    role_nxt = role_r;
    pol_nxt = pol_r;
    pha_nxt = pha_r;
    rate_nxt = rate_r;
    tdf_nxt = tdf_r;
    write_collision_flag_nxt = write_collision_flag_r;
    ovr_nxt = ovr_r;
    mode_fault_flag_nxt = mode_fault_flag_r;
    tdf_seen_nxt = tdf_seen_r;
    write_collision_flag_seen_nxt = write_collision_flag_seen_r;
    mode_fault_flag_seen_nxt = mode_fault_flag_seen_r;
    sh_nxt = sh_r;
    rxb_nxt = rxb_r;
    in_nxt = in_r;
    cnt_nxt = cnt_r;
    div_nxt = div_r;
    sck_nxt = sck_r;
    mst_nxt = mst_r;
    done = 1'b0;
    byte_in = {sh_r[6:0], in_r};
    // cpu accesses, all frozen in halt
    if (!HALT) begin
      if (CSR_RD) begin
        ovr_nxt = 1'b0;
        if (tdf_r) tdf_seen_nxt = 1'b1;
        if (write_collision_flag_r) write_collision_flag_seen_nxt = 1'b1;
        if (mode_fault_flag_r) mode_fault_flag_seen_nxt = 1'b1;
      end
      if ((DR_RD || DR_WR) && tdf_seen_r) begin
        tdf_nxt = 1'b0;
        tdf_seen_nxt = 1'b0;
      end
      if ((DR_RD || DR_WR) && write_collision_flag_seen_r) begin
        write_collision_flag_nxt = 1'b0;
        write_collision_flag_seen_nxt = 1'b0;
      end
      if (CR_WR) begin
        irq_en_nxt = IRQ_ENABLE_BIT_IN;
        pol_nxt = CLOCK_POLARITY_SEL_IN;
        pha_nxt = CLOCK_PHASE_SEL_IN;
        rate_nxt = RATE_SEL_IN;
        // only clearing is allowed until the fault sequence completes
        if (mode_fault_flag_r && !mode_fault_flag_seen_r) begin
          pe_nxt = pe_r & PORT_ENABLE_BIT_IN;
          role_nxt = role_r & CONTROLLER_ROLE_BIT_IN;
        end else begin
          pe_nxt = PORT_ENABLE_BIT_IN;
          role_nxt = CONTROLLER_ROLE_BIT_IN;
        end
        if (mode_fault_flag_seen_r) begin
          mode_fault_flag_nxt = 1'b0;
          mode_fault_flag_seen_nxt = 1'b0;
        end
      end
      if (dr_ok) begin
        if (busy) begin
          write_collision_flag_nxt = 1'b1;
        end else begin
          sh_nxt = DR_WDATA;
          cnt_nxt = smfw_pkg::CNT_RST;
          if (role_r && pe_r) begin
            mst_nxt = smfw_pkg::ST_RUN;
            div_nxt = half_reload(rate_r);
            sck_nxt = pol_r;
          end
        end
      end
    end
    // master clock generator
    if (mst_r == smfw_pkg::ST_RUN && !HALT) begin
      if (div_r == 6'h00) begin
        div_nxt = half_reload(rate_r);
        sck_nxt = ~sck_r;
      end else begin
        div_nxt = div_r - 6'h01;
      end
    end else if (mst_r == smfw_pkg::ST_IDLE) begin
      sck_nxt = pol_r;
    end
    // one shift register carries both directions
    if (samp) begin
      in_nxt = din;
      cnt_nxt = cnt_r + 4'h1;
      if (pha_r && cnt_r == smfw_pkg::LAST_SAMPLE) begin
        done = 1'b1;
        byte_in = {sh_r[6:0], din};
        sh_nxt = byte_in;
        cnt_nxt = smfw_pkg::CNT_RST;
      end
    end
    if (shft && cnt_r != smfw_pkg::CNT_RST) begin
      sh_nxt = {sh_r[6:0], in_r};
      if (!pha_r && cnt_r == smfw_pkg::BYTE_BITS) begin
        done = 1'b1;
        cnt_nxt = smfw_pkg::CNT_RST;
      end
    end
    // deselected slave drops a partial byte
    if (!role_r && sel_int) cnt_nxt = smfw_pkg::CNT_RST;
    if (done) begin
      mst_nxt = smfw_pkg::ST_IDLE;
      if (tdf_r) begin
        ovr_nxt = 1'b1;
        // a clear in this same cycle loses to the new byte
        tdf_nxt = 1'b1;
      end else begin
        rxb_nxt = byte_in;
        tdf_nxt = 1'b1;
      end
    end
    if (fault) begin
      mode_fault_flag_nxt = 1'b1;
      mode_fault_flag_seen_nxt = 1'b0;
      pe_nxt = 1'b0;
      role_nxt = 1'b0;
    end
    if (!pe_nxt) begin
      mst_nxt = smfw_pkg::ST_IDLE;
      cnt_nxt = smfw_pkg::CNT_RST;
    end
    // arm halt wake-up only if selected as slave at entry
    arm_nxt = arm_r;
    if (HALT && !halt_d_r) arm_nxt = pe_r & ~role_r & ~sel_int;
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      {irq_en_r, pe_r, role_r, pol_r, pha_r} <= 5'h00;
      rate_r <= smfw_pkg::RATE_RST;
      {tdf_r, write_collision_flag_r, ovr_r, mode_fault_flag_r} <= 4'h0;
      {tdf_seen_r, write_collision_flag_seen_r, mode_fault_flag_seen_r} <= 3'h0;
      sh_r <= smfw_pkg::BYTE_RST;
      rxb_r <= smfw_pkg::BYTE_RST;
      {in_r, sck_r, halt_d_r, arm_r} <= 4'h0;
      cnt_r <= smfw_pkg::CNT_RST;
      div_r <= smfw_pkg::DIV_RST;
      mst_r <= smfw_pkg::ST_IDLE;
    end else begin
      irq_en_r <= irq_en_nxt;
      pe_r <= pe_nxt;
      role_r <= role_nxt;
      pol_r <= pol_nxt;
      pha_r <= pha_nxt;
      rate_r <= rate_nxt;
      tdf_r <= tdf_nxt;
      write_collision_flag_r <= write_collision_flag_nxt;
      ovr_r <= ovr_nxt;
      mode_fault_flag_r <= mode_fault_flag_nxt;
      tdf_seen_r <= tdf_seen_nxt;
      write_collision_flag_seen_r <= write_collision_flag_seen_nxt;
      mode_fault_flag_seen_r <= mode_fault_flag_seen_nxt;
      sh_r <= sh_nxt;
      rxb_r <= rxb_nxt;
      in_r <= in_nxt;
      sck_r <= sck_nxt;
      halt_d_r <= HALT;
      arm_r <= arm_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      mst_r <= mst_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign DR_RDATA = rxb_r;
  assign SCK_O = sck_r;
  assign SCK_OE = pe_r & role_r;
  assign MOSI_O = sh_r[7];
  assign MOSI_OE = pe_r & role_r & ~OUTPUT_DISABLE;
  assign MISO_O = sh_r[7];
  assign MISO_OE = pe_r & ~role_r & ~sel_int & ~OUTPUT_DISABLE;
  assign TRANSFER_DONE_FLAG = tdf_r;
  assign WRITE_COLLISION_FLAG = write_collision_flag_r;
  assign OVERRUN_FLAG = ovr_r;
  assign MODE_FAULT_FLAG = mode_fault_flag_r;
  assign PORT_ENABLE_BIT = pe_r;
  assign CONTROLLER_ROLE_BIT = role_r;
  // collision flag deliberately left out of the request
  assign IRQ = irq_en_r & (tdf_r | mode_fault_flag_r | ovr_r) & ~COND_CODE_MASK;
  assign WAKE_HALT = HALT & arm_r & ~role_r & tdf_r & irq_en_r & ~COND_CODE_MASK;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  a_fault_entry: assert property (fault |=> mode_fault_flag_r && !pe_r && !role_r)
    else $error("fault did not drop enable and role");
  a_fault_refuse: assert property (
    mode_fault_flag_r && !mode_fault_flag_seen_r && CR_WR && !pe_r |=> !pe_r)
    else $error("enable set during fault");
  a_fault_clear: assert property ($fell(mode_fault_flag_r) |-> $past(CR_WR && mode_fault_flag_seen_r))
    else $error("fault flag cleared without sequence");
  a_overrun_set: assert property (done && tdf_r |=> ovr_r && $stable(rxb_r))
    else $error("overrun not flagged or buffer changed");
  a_overrun_clear: assert property (CSR_RD && !HALT && !done |=> !ovr_r)
    else $error("overrun survived status read");
  a_collide_set: assert property (dr_ok && busy |=> write_collision_flag_r)
    else $error("collision not flagged");
  a_irq_cause: assert property (IRQ |-> irq_en_r && (tdf_r || mode_fault_flag_r || ovr_r))
    else $error("interrupt without enabled event");
  a_done_byte: assert property (done && !tdf_r |=> tdf_r && rxb_r == $past(byte_in))
    else $error("byte not delivered to buffer");
  a_idle_level: assert property (
    mst_r == smfw_pkg::ST_IDLE && $past(mst_r == smfw_pkg::ST_IDLE) && $stable(pol_r)
    |-> sck_r == pol_r)
    else $error("idle clock level wrong");
  a_write_block: assert property (
    DR_WR && tdf_r && !tdf_seen_r && mst_r == smfw_pkg::ST_IDLE |=> mst_r == smfw_pkg::ST_IDLE)
    else $error("blocked write started a transfer");
  // cycles spent in one master byte, frozen in halt like the byte itself
  logic [10:0] run_cyc_r, run_cyc_nxt;

  always_comb begin
    run_cyc_nxt = run_cyc_r;
    if (mst_r == smfw_pkg::ST_IDLE) run_cyc_nxt = smfw_pkg::RUN_RST;
    else if (!HALT) run_cyc_nxt = run_cyc_r + 11'h001;
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) run_cyc_r <= smfw_pkg::RUN_RST;
    else run_cyc_r <= run_cyc_nxt;
  end

  a_master_ends: assert property (run_cyc_r <= smfw_pkg::RUN_LIMIT)
    else $error("master byte did not finish");
  a_halt_wake: assert property (WAKE_HALT |-> arm_r && tdf_r && !role_r)
    else $error("halt wake without armed slave");

  c_byte_done: cover property (done && !tdf_r);
  c_overrun: cover property (done && tdf_r);
  c_fault: cover property (fault);
  c_halt_wake: cover property (WAKE_HALT);

endmodule : smfw_core

/* rtl/smfw_pkg.sv */
// shared constants and types for the serial port fault and wake block
// assumes: compiled ahead of the serial port module
package smfw_pkg;

  // ---------------------------------------------------------------
  // master clock divider: reload value is half period minus one
  // ---------------------------------------------------------------
  localparam logic [5:0] HALF_DIV4 = 6'h01;
  localparam logic [5:0] HALF_DIV8 = 6'h03;
  localparam logic [5:0] HALF_DIV16 = 6'h07;
  localparam logic [5:0] HALF_DIV32 = 6'h0f;
  localparam logic [5:0] HALF_DIV64 = 6'h1f;
  localparam logic [5:0] HALF_DIV128 = 6'h3f;

  // rate select codes {divider enable, rate1, rate0}
  localparam logic [2:0] RATE_DIV4 = 3'h4;
  localparam logic [2:0] RATE_DIV8 = 3'h0;
  localparam logic [2:0] RATE_DIV16 = 3'h1;
  localparam logic [2:0] RATE_DIV32 = 3'h6;
  localparam logic [2:0] RATE_DIV64 = 3'h2;
  localparam logic [2:0] RATE_DIV128 = 3'h3;

  // ---------------------------------------------------------------
  // byte framing and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_SAMPLE = 4'h7;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [5:0] DIV_RST = 6'h00;
  // cycle allowance for one master byte at the slowest rate
  localparam logic [10:0] RUN_RST = 11'h000;
  localparam logic [10:0] RUN_LIMIT = 11'h44c;

  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} smfw_mst_t;

endpackage : smfw_pkg

/* verification/smfw_remote.sv */
// remote party model for the serial port link
// assumes: bench resolves shared pin levels and calls xfer or select
`timescale 1ns/1ps

module smfw_remote (
  output logic sck,
  output logic mosi,
  output logic sel_n,
  input wire logic miso,
  input wire logic mosi_in,
  output logic resp
);
  // ----------------------------------------
  // remote slave role: returns complement of bits heard
  // ----------------------------------------
  assign resp = ~mosi_in;

  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    sel_n = 1'b1;
  end

  task automatic select(input logic v);
    sel_n = v;
  endtask : select

  // ----------------------------------------
  // remote master role: one byte, 125 ns clock, msb first
  // ----------------------------------------
  task automatic xfer(input logic pol, input logic pha, input logic [7:0] tx,
                      output logic [7:0] rx);
    // settle the idle level before selecting, so no false edge is seen
    if (sck !== pol) begin
      sck = pol;
      #62.5;
    end
    sel_n = 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--) begin
      if (!pha) mosi = tx[i];
      #62.5 sck = ~pol;
      if (pha) mosi = tx[i];
      else rx[i] = miso;
      #62.5 sck = pol;
      if (pha) rx[i] = miso;
    end
    #62.5 sel_n = 1'b1;
    mosi = ~mosi;
  endtask : xfer
endmodule : smfw_remote

/* verification/tb_spi_mode_fault_and_wake_logic.sv */
// self-checking bench for the serial port fault and wake block
// assumes: smfw_core and smfw_remote compiled first
`timescale 1ns/1ps

module tb_spi_mode_fault_and_wake_logic;
  logic clk = 1'b0, rst = 1'b1, cr_wr = 1'b0, csr_rd = 1'b0, dr_wr = 1'b0, dr_rd = 1'b0;
  logic irq_in = 1'b0, pe_in = 1'b0, role_in = 1'b0, pol_in = 1'b0, pha_in = 1'b0;
  logic [2:0] rate_in = 3'h0;
  logic [7:0] wdata = 8'h00, got, rdata;
  logic soft_m = 1'b0, soft_l = 1'b1, out_dis = 1'b0, mask = 1'b0, halt = 1'b0;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_sck, p_mosi, p_sel_n, p_resp;
  logic done, write_collision_flag, overrun_flag, fault, pe, role, irq, wake;
  int errors = 0, checks = 0, cyc = 0;
  wire sck_w = sck_oe ? sck_o : p_sck;
  wire mosi_w = mosi_oe ? mosi_o : p_mosi;
  wire miso_w = miso_oe ? miso_o : p_resp;

  smfw_core smfw_core_i (.CLK_SYS(clk), .SYS_RST(rst), .CR_WR(cr_wr),
    .IRQ_ENABLE_BIT_IN(irq_in), .PORT_ENABLE_BIT_IN(pe_in), .CONTROLLER_ROLE_BIT_IN(role_in),
    .CLOCK_POLARITY_SEL_IN(pol_in), .CLOCK_PHASE_SEL_IN(pha_in), .RATE_SEL_IN(rate_in),
    .CSR_RD(csr_rd), .SELECT_SOFT_MGMT(soft_m), .SELECT_SOFT_LEVEL(soft_l),
    .OUTPUT_DISABLE(out_dis), .DR_WR(dr_wr), .DR_WDATA(wdata), .DR_RD(dr_rd),
    .DR_RDATA(rdata), .COND_CODE_MASK(mask), .HALT(halt), .SCK_I(sck_w), .SCK_O(sck_o),
    .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w),
    .MISO_O(miso_o), .MISO_OE(miso_oe), .SEL_N_I(p_sel_n), .TRANSFER_DONE_FLAG(done),
    .WRITE_COLLISION_FLAG(write_collision_flag), .OVERRUN_FLAG(overrun_flag), .MODE_FAULT_FLAG(fault),
    .PORT_ENABLE_BIT(pe), .CONTROLLER_ROLE_BIT(role), .IRQ(irq), .WAKE_HALT(wake));

  smfw_remote smfw_remote_i (.sck(p_sck), .mosi(p_mosi), .sel_n(p_sel_n), .miso(miso_w),
    .mosi_in(mosi_w), .resp(p_resp));

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks = checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // control word {irq, enable, role, polarity, phase, rate}
  task automatic cr(input logic [7:0] v);
    @(negedge clk);
    {irq_in, pe_in, role_in, pol_in, pha_in, rate_in} = v;
    cr_wr = 1'b1;
    @(negedge clk);
    cr_wr = 1'b0;
  endtask : cr

  task automatic csr();
    @(negedge clk);
    csr_rd = 1'b1;
    @(negedge clk);
    csr_rd = 1'b0;
  endtask : csr

  task automatic drd();
    @(negedge clk);
    dr_rd = 1'b1;
    @(negedge clk);
    dr_rd = 1'b0;
  endtask : drd

  task automatic dwr(input logic [7:0] d);
    @(negedge clk);
    wdata = d;
    dr_wr = 1'b1;
    @(negedge clk);
    dr_wr = 1'b0;
  endtask : dwr

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_master();
    cr(8'hf3);
    idle(4);
    chk(sck_o, 1'b1);
    dwr(8'ha5);
    dwr(8'h0f);
    chk(write_collision_flag, 1'b1);
    chk(irq, 1'b0);
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
    idle(2);
    chk(rdata, 8'h5a);
    chk(irq, 1'b1);
    mask = 1'b1;
    idle(1);
    chk(irq, 1'b0);
    mask = 1'b0;
    dwr(8'hff);
    idle(70);
    chk(sck_o, 1'b1);
    csr();
    drd();
    idle(1);
    chk(done, 1'b0);
    chk(write_collision_flag, 1'b0);
    cr(8'h00);
    $display("test master done");
  endtask : t_master

  task automatic t_fault();
    cr(8'hf3);
    smfw_remote_i.select(1'b0);
    for (int i = 0; i < 50 && fault !== 1'b1; i++) @(negedge clk);
    idle(1);
    chk({pe, role, sck_oe}, 3'h0);
    chk(irq, 1'b1);
    cr(8'hf3);
    idle(1);
    chk(pe, 1'b0);
    smfw_remote_i.select(1'b1);
    idle(4);
    csr();
    cr(8'hf3);
    idle(1);
    chk({fault, pe, role}, 3'h3);
    cr(8'h00);
    $display("test fault done");
  endtask : t_fault

  task automatic t_slave_modes();
    for (int m = 0; m < 4; m++) begin
      cr(8'h00);
      cr({3'h2, m[1:0], 3'h0});
      dwr(8'h90 + m[7:0]);
      smfw_remote_i.xfer(m[1], m[0], 8'h3c + m[7:0], got);
      idle(4);
      chk(got, 8'h90 + m[7:0]);
      chk(rdata, 8'h3c + m[7:0]);
      chk(done, 1'b1);
      csr();
      drd();
    end
    $display("test slave modes done");
  endtask : t_slave_modes

  task automatic t_overrun();
    cr(8'hd8);
    smfw_remote_i.xfer(1'b1, 1'b1, 8'h11, got);
    chk(got, 8'h3f);
    smfw_remote_i.xfer(1'b1, 1'b1, 8'h22, got);
    idle(4);
    chk({overrun_flag, irq}, 2'h3);
    smfw_remote_i.xfer(1'b1, 1'b1, 8'h33, got);
    idle(4);
    chk(rdata, 8'h11);
    csr();
    idle(1);
    chk(overrun_flag, 1'b0);
    drd();
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_halt();
    soft_m = 1'b1;
    soft_l = 1'b0;
    idle(4);
    halt = 1'b1;
    idle(2);
    chk(wake, 1'b0);
    cr(8'h00);
    chk(pe, 1'b1);
    smfw_remote_i.xfer(1'b1, 1'b1, 8'h44, got);
    idle(4);
    chk(wake, 1'b1);
    smfw_remote_i.xfer(1'b1, 1'b1, 8'h55, got);
    idle(4);
    chk(overrun_flag, 1'b1);
    halt = 1'b0;
    csr();
    drd();
    chk(rdata, 8'h44);
    smfw_remote_i.xfer(1'b1, 1'b1, 8'h66, got);
    idle(4);
    chk(rdata, 8'h66);
    csr();
    drd();
    soft_m = 1'b0;
    soft_l = 1'b1;
    cr(8'h00);
    $display("test halt done");
  endtask : t_halt

  initial begin
    idle(6);
    rst = 1'b0;
    idle(4);
    chk({done, write_collision_flag, overrun_flag, fault, pe, role, irq, sck_oe}, 8'h00);
    t_master();
    t_fault();
    t_slave_modes();
    t_overrun();
    t_halt();
    test_done();
  end
endmodule : tb_spi_mode_fault_and_wake_logic
